/* hw/pe_tape_control.sv */
`timescale 1ns/1ps
module pe_tape_control #(
  parameter int unsigned PAUSE_CYCLES = pe_tape_pkg::PAUSE_CYCLES, // pause length
  parameter int unsigned TIMEOUT_CYCLES = pe_tape_pkg::TIMEOUT_CYCLES, // completion limit
  parameter logic [6:0] CONTROL_ID = 7'h2a // arbitrary identity value
) (
  input wire logic clk, // clock
  input wire logic reset, // sync reset, active high
  input wire logic op_start, // pulse, new operator accepted
  input wire pe_tape_pkg::op_t op_code, // operator class, valid with op_start
  input wire logic op_backward, // direction variant
  input wire logic op_space_eof, // space to end of file variant
  input wire logic [1:0] op_store_mode, // Test storage protocol
  input wire logic [3:0] unit_select_field, // drive code
  input wire logic [3:0] diag_channel_field, // diagnostic channel bits
  input wire logic [1:0] subsystem_num, // strapped subsystem number
  input wire logic unit_present, // drive answers
  input wire logic unit_ready, // drive ready
  input wire logic unit_busy, // drive busy
  input wire logic unit_pe, // drive is phase-encoded capable
  input wire logic unit_invalid_op, // drive reported invalid operation
  input wire logic unit_rewinding, // drive rewinding
  input wire logic unit_cmd_rewind, // rewind was commanded
  input wire logic unit_write_ring, // write ring present
  input wire logic unit_at_eot, // at or past end-of-tape point
  input wire logic unit_at_bot, // load point marker seen
  input wire logic init_parity_err, // pulse, op-code transfer parity error
  input wire logic data_parity_err, // pulse, data transfer parity error
  input wire logic result_parity_err, // pulse, result transfer parity error
  input wire logic deu_timeout, // pulse, drive failed to start
  input wire logic hard_data_err, // pulse, uncorrectable data error
  input wire logic soft_data_err, // pulse, correctable data error
  input wire logic erase_data_seen, // pulse, data found after erase
  input wire logic tape_mark_seen, // pulse, tape mark read
  input wire logic amble_start, // pulse, preamble or postamble starts
  input wire logic amble_char_valid, // pulse, amble character
  input wire logic [7:0] amble_char, // amble character value
  input wire logic amble_done, // pulse, amble ends
  input wire logic motion_done, // pulse, drive finished motion
  output logic [4:0] drive_number, // selected drive 1..16
  output logic motion_enable, // level, drive may move tape
  output logic data_xfer_enable, // level, data may pass to processor
  output logic stop_motion, // level, halt drive now
  output logic diag_hold, // level, drive interaction blocked
  output logic diag_read, // level, simulated data read
  output logic force_even_parity, // level, even parity forced
  output logic service_req, // pulse, result ready
  output logic [23:0] result_status_field, // result, bit 0 at msb
  output logic interrupt_req // pulse, with service_req
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PAUSE, ST_DONE} state_t;
  localparam int RW = pe_tape_pkg::RESULT_W;

  state_t state_ff, nxt_state;
  pe_tape_pkg::op_t op_ff;
  logic back_ff, eof_ff;
  logic [1:0] ss_ff;
  logic [3:0] unit_ff;
  logic [RW-1:0] acc_ff; // sticky error bits, index = bit number
  logic bot_ff;
  logic parity_hold_ff;
  logic [RW-1:0] res_ff;
  logic srq_ff, irq_ff;

  wire rdy = unit_ready || diag_channel_field[pe_tape_pkg::DIAG_READY];
  wire not_ready_now = !unit_present || !rdy || unit_busy;
  wire is_rw = (op_code == pe_tape_pkg::OP_READ) || (op_code == pe_tape_pkg::OP_SPACE);
  wire is_wr = (op_code == pe_tape_pkg::OP_WRITE) || (op_code == pe_tape_pkg::OP_ERASE);
  wire is_rew = (op_code == pe_tape_pkg::OP_REWIND) || (op_code == pe_tape_pkg::OP_REWIND_UNLOAD);
  wire is_test = (op_code == pe_tape_pkg::OP_TEST);
  wire is_pause = (op_code == pe_tape_pkg::OP_PAUSE);
  wire backward_op = (is_rw && op_backward) || (op_code == pe_tape_pkg::OP_REWIND);
  wire run_op = (op_ff != pe_tape_pkg::OP_TEST) && (op_ff != pe_tape_pkg::OP_PAUSE);
  wire run_rw = (op_ff == pe_tape_pkg::OP_READ) || (op_ff == pe_tape_pkg::OP_SPACE);
  wire run_wr = (op_ff == pe_tape_pkg::OP_WRITE) || (op_ff == pe_tape_pkg::OP_ERASE);

  // start-time refusals end with no tape movement
  wire start_nr = op_start && !is_test && !is_pause && (not_ready_now ||
                  (unit_rewinding && !is_rew && !unit_cmd_rewind) || init_parity_err);
  wire start_nopass = op_start && !is_test && !is_pause && !unit_pe;
  wire start_lock = op_start && is_wr && !unit_write_ring;
  wire start_bot = op_start && backward_op && unit_at_bot;
  wire start_rewinding = op_start && !is_rew && !is_pause && unit_rewinding && rdy;
  wire start_end = start_nr || start_nopass || start_lock || start_bot || (op_start && is_test);

  wire amble_bad;
  wire tmo_4s;
  wire pause_done;

  pe_tape_preamble_check u_amble (
    .clk(clk),
    .reset(reset),
    .start(amble_start),
    .char_valid(amble_char_valid),
    .char_data(amble_char),
    .done(amble_done),
    .bad(amble_bad)
  );

  // no 4 s watchdog while spacing to end of file
  pe_tape_timer #(.LIMIT(TIMEOUT_CYCLES)) u_tmo (
    .clk(clk),
    .reset(reset),
    .run(state_ff == ST_RUN && !(run_rw && eof_ff && op_ff == pe_tape_pkg::OP_SPACE)),
    .expired(tmo_4s)
  );

  pe_tape_timer #(.LIMIT(PAUSE_CYCLES)) u_pause (
    .clk(clk),
    .reset(reset),
    .run(state_ff == ST_PAUSE),
    .expired(pause_done)
  );

  // data errors: write and erase report soft ones, erase also reports data found after erase
  wire data_err_ev = hard_data_err || amble_bad || (soft_data_err && run_wr) ||
                     (erase_data_seen && op_ff == pe_tape_pkg::OP_ERASE);
  wire mid_nr = state_ff == ST_RUN && not_ready_now;
  wire bot_hit = state_ff == ST_RUN && back_ff && unit_at_bot;
  wire run_end = state_ff == ST_RUN && (motion_done || mid_nr || tmo_4s || bot_hit);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (op_start)
          nxt_state = is_pause ? ST_PAUSE : (start_end ? ST_DONE : ST_RUN);
      ST_RUN:
        if (run_end)
          nxt_state = ST_DONE;
      ST_PAUSE:
        if (pause_done)
          nxt_state = ST_DONE;
      ST_DONE:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_ff <= pe_tape_pkg::OP_NONE;
      back_ff <= 1'b0;
      eof_ff <= 1'b0;
      ss_ff <= 2'h0;
      unit_ff <= 4'h0;
    end
    else if (state_ff == ST_IDLE && op_start)
    begin
      op_ff <= op_code;
      back_ff <= backward_op;
      eof_ff <= op_space_eof;
      ss_ff <= op_store_mode;
      unit_ff <= unit_select_field;
    end
  end

  // sticky status; a new start clears, events in the same cycle still set
  logic [RW-1:0] ev;
  always_comb
  begin
    ev = '0;
    ev[pe_tape_pkg::B_NOT_READY] = start_nr || start_nopass || mid_nr;
    ev[pe_tape_pkg::B_DATA_ERR] = state_ff == ST_RUN && data_err_ev;
    ev[pe_tape_pkg::B_WLOCK] = start_lock;
    ev[pe_tape_pkg::B_MARK] = state_ff == ST_RUN && run_rw && tape_mark_seen;
    ev[pe_tape_pkg::B_REWINDING] = start_rewinding;
    ev[pe_tape_pkg::B_TIMEOUT] = tmo_4s || deu_timeout;
    ev[pe_tape_pkg::B_XMIT_DEU] = init_parity_err ||
                                  (state_ff == ST_RUN && data_parity_err && run_wr);
    ev[pe_tape_pkg::B_XMIT_CTL] = (state_ff == ST_RUN && data_parity_err && !run_wr) ||
                                  result_parity_err;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      acc_ff <= '0;
    else if (state_ff == ST_IDLE && op_start)
      acc_ff <= ev;
    else if (state_ff != ST_IDLE)
      acc_ff <= acc_ff | ev;
  end

  // load point memory held until forward motion leaves it
  always_ff @(posedge clk)
  begin
    if (reset)
      bot_ff <= 1'b0;
    else if (bot_hit || start_bot)
      bot_ff <= 1'b1;
    else if (state_ff == ST_RUN && !back_ff && !unit_at_bot)
      bot_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      parity_hold_ff <= 1'b0;
    else
      parity_hold_ff <= diag_channel_field[pe_tape_pkg::DIAG_PARITY];
  end

  // result assembly; undefined positions stay zero
  logic [RW-1:0] res_bits;
  logic test_store;
  logic [2:0] dens;
  always_comb
  begin
    res_bits = '0;
    dens = (unit_invalid_op && rdy) ? pe_tape_pkg::DENS_800 : pe_tape_pkg::DENS_1600;
    res_bits[pe_tape_pkg::B_COMPLETE] = 1'b1;
    test_store = 1'b1;
    if (op_ff == pe_tape_pkg::OP_TEST)
    begin
      res_bits[pe_tape_pkg::B_NOT_READY] = not_ready_now;
      res_bits[3] = subsystem_num[1];
      res_bits[4] = subsystem_num[0];
      res_bits[pe_tape_pkg::B_XMIT_TEST] = acc_ff[pe_tape_pkg::B_XMIT_DEU] ||
                                           acc_ff[pe_tape_pkg::B_XMIT_CTL] || result_parity_err;
      res_bits[pe_tape_pkg::B_EOT] = unit_at_eot;
      res_bits[pe_tape_pkg::B_BOT] = unit_at_bot;
      res_bits[pe_tape_pkg::B_WLOCK] = !unit_write_ring;
      res_bits[pe_tape_pkg::B_MARK] = unit_present;
      res_bits[pe_tape_pkg::B_REWINDING] = unit_rewinding;
      {res_bits[pe_tape_pkg::B_DENS_HI], res_bits[13], res_bits[14]} = dens;
      for (int i = 0; i < 7; i++)
        res_bits[pe_tape_pkg::B_ID_HI + i] = CONTROL_ID[6 - i];
      res_bits[pe_tape_pkg::B_EXCEPTION] = |{res_bits[2], res_bits[8:5], res_bits[14:10]} ||
                                           !res_bits[pe_tape_pkg::B_MARK];
      case (ss_ff)
        pe_tape_pkg::SS_ALWAYS: test_store = 1'b1;
        pe_tape_pkg::SS_NOT_READY: test_store = not_ready_now;
        pe_tape_pkg::SS_READY: test_store = !not_ready_now && !unit_rewinding;
        default: test_store = 1'b0;
      endcase
      res_bits[pe_tape_pkg::B_STORE] = test_store;
    end
    else if (op_ff == pe_tape_pkg::OP_PAUSE)
      res_bits[pe_tape_pkg::B_STORE] = 1'b0;
    else
    begin
      res_bits = acc_ff;
      res_bits[pe_tape_pkg::B_COMPLETE] = 1'b1;
      res_bits[pe_tape_pkg::B_STORE] = 1'b1;
      res_bits[pe_tape_pkg::B_EOT] = unit_at_eot && run_op;
      res_bits[pe_tape_pkg::B_BOT] = (bot_ff || bot_hit) && op_ff != pe_tape_pkg::OP_REWIND_UNLOAD;
      res_bits[pe_tape_pkg::B_EXCEPTION] = |res_bits[11:2] || res_bits[pe_tape_pkg::B_XMIT_DEU] ||
                                           res_bits[pe_tape_pkg::B_XMIT_CTL];
    end
  end

  // msb of the word is descriptor bit 0
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      res_ff <= '0;
      srq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      srq_ff <= state_ff == ST_DONE;
      irq_ff <= state_ff == ST_DONE && res_bits[pe_tape_pkg::B_EXCEPTION];
      if (state_ff == ST_DONE)
        for (int i = 0; i < RW; i++)
          res_ff[RW - 1 - i] <= res_bits[i];
    end
  end

  assign drive_number = (unit_ff == pe_tape_pkg::UNIT_CODE_16) ? pe_tape_pkg::UNIT_NUM_16 : {1'b0, unit_ff};
  assign diag_hold = diag_channel_field[pe_tape_pkg::DIAG_HOLD];
  assign diag_read = diag_channel_field[pe_tape_pkg::DIAG_READ];
  assign force_even_parity = parity_hold_ff;
  assign motion_enable = state_ff == ST_RUN && run_op && !diag_hold;
  assign stop_motion = mid_nr || bot_hit;
  assign data_xfer_enable = motion_enable && !(run_rw && (eof_ff || acc_ff[pe_tape_pkg::B_MARK]));
  assign service_req = srq_ff;
  assign result_status_field = res_ff;
  assign interrupt_req = irq_ff;
endmodule : pe_tape_control

/* hw/pe_tape_pkg.sv */
package pe_tape_pkg;
  // operation classes seen by the result logic
  typedef enum logic [3:0] {
    OP_READ, OP_SPACE, OP_WRITE, OP_ERASE, OP_REWIND, OP_REWIND_UNLOAD, OP_TEST, OP_PAUSE, OP_NONE
  } op_t;

  localparam int RESULT_W = 24;
  // result bit positions, bit 0 is the msb of the descriptor word as printed
  localparam int B_COMPLETE = 0;
  localparam int B_EXCEPTION = 1;
  localparam int B_NOT_READY = 2;
  localparam int B_DATA_ERR = 3;
  localparam int B_ACCESS_ERR = 4;
  localparam int B_XMIT_TEST = 5;
  localparam int B_EOT = 6;
  localparam int B_BOT = 7;
  localparam int B_WLOCK = 8;
  localparam int B_MARK = 9;
  localparam int B_REWINDING = 10;
  localparam int B_TIMEOUT = 11;
  localparam int B_DENS_HI = 12;
  localparam int B_STORE = 16;
  localparam int B_ID_HI = 17;
  localparam int B_XMIT_DEU = 21;
  localparam int B_XMIT_CTL = 22;

  localparam logic [2:0] DENS_800 = 3'h5;
  localparam logic [2:0] DENS_1600 = 3'h7;
  localparam logic [1:0] SS_ALWAYS = 2'h0;
  localparam logic [1:0] SS_NOT_READY = 2'h1;
  localparam logic [1:0] SS_READY = 2'h2;
  localparam logic [3:0] UNIT_CODE_16 = 4'h0;
  localparam logic [4:0] UNIT_NUM_16 = 5'h10;

  localparam int PREAMBLE_ZEROS_MIN = 36;
  localparam int PREAMBLE_ZEROS_MAX = 44;
  localparam logic [7:0] MARKER_CHAR = 8'hff;

  localparam int CLK_MHZ = 100;
  localparam int PAUSE_US = 4500;
  localparam int PAUSE_CYCLES = PAUSE_US * CLK_MHZ;
  localparam int TIMEOUT_MS = 4000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;

  // diagnostic channel field bit positions
  localparam int DIAG_HOLD = 3;
  localparam int DIAG_READ = 2;
  localparam int DIAG_READY = 1;
  localparam int DIAG_PARITY = 0;
endpackage : pe_tape_pkg

/* hw/pe_tape_preamble_check.sv */
`timescale 1ns/1ps
module pe_tape_preamble_check (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic start, // pulse, new preamble or postamble begins
  input wire logic char_valid, // pulse, one character of it
  input wire logic [7:0] char_data, // character value
  input wire logic done, // pulse, field ended
  output logic bad // pulse, field malformed
);
  logic [5:0] zeros_ff;
  logic marker_ff;
  logic bad_ff;
  wire is_zero = char_valid && (char_data == 8'h00);
  wire is_mark = char_valid && (char_data == pe_tape_pkg::MARKER_CHAR);
  wire count_bad = (zeros_ff > 6'(pe_tape_pkg::PREAMBLE_ZEROS_MAX)) ||
                   (zeros_ff < 6'(pe_tape_pkg::PREAMBLE_ZEROS_MIN));

  always_ff @(posedge clk)
  begin
    if (reset || start)
    begin
      zeros_ff <= 6'h00;
      marker_ff <= 1'b0;
    end
    else
    begin
      if (is_zero && zeros_ff != 6'h3f)
        zeros_ff <= zeros_ff + 6'h01;
      if (is_mark)
        marker_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      bad_ff <= 1'b0;
    else
      bad_ff <= done && (count_bad || !marker_ff);
  end

  assign bad = bad_ff;
endmodule : pe_tape_preamble_check

/* hw/pe_tape_timer.sv */
`timescale 1ns/1ps
module pe_tape_timer #(
  parameter int unsigned LIMIT = 100
) (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic run, // count while high, clear when low
  output logic expired // level, limit reached
);
  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  wire at_limit = (count_ff >= 32'(LIMIT - 1));

  assign nxt_count = !run ? 32'h0000_0000 : (at_limit ? count_ff : count_ff + 32'h0000_0001);

  always_ff @(posedge clk)
  begin
    if (reset)
      count_ff <= 32'h0000_0000;
    else
      count_ff <= nxt_count;
  end

  assign expired = run && at_limit;
endmodule : pe_tape_timer

/* verif/pe_tape_control_properties.sv */
`timescale 1ns/1ps
module pe_tape_control_properties #(
  parameter int unsigned PAUSE_CYCLES = 20 // pause length
) (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic op_start, // op pulse
  input wire pe_tape_pkg::op_t op_code, // op class
  input wire logic [3:0] unit_select_field, // drive code
  input wire logic [3:0] diag_channel_field, // diag bits
  input wire logic unit_ready, // ready
  input wire logic unit_invalid_op, // 800 bpi flag
  input wire logic unit_write_ring, // ring
  input wire logic [4:0] drive_number, // drive
  input wire logic motion_enable, // motion
  input wire logic diag_hold, // hold
  input wire logic diag_read, // diag read
  input wire logic force_even_parity, // parity
  input wire logic service_req, // done pulse
  input wire logic [23:0] result_status_field, // result
  input wire logic interrupt_req // irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  pe_tape_pkg::op_t last_ff;
  int unsigned cnt_ff;
  logic rdy;
  logic is_test;
  logic [23:0] rs;
  assign rs = result_status_field;
  assign rdy = unit_ready | diag_channel_field[1];
  assign is_test = last_ff == pe_tape_pkg::OP_TEST;
  // op_start only comes in idle, so it always names the running op
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      last_ff <= pe_tape_pkg::OP_NONE;
      cnt_ff <= 0;
    end
    else if (op_start)
    begin
      last_ff <= op_code;
      cnt_ff <= 0;
    end
    else
      cnt_ff <= cnt_ff + 1;
  end
  a_exc_summary: assert property (service_req && !is_test && (|rs[21:12] || |rs[2:1]) |-> rs[22])
    else $error("exception bit missing");
  a_irq_follow: assert property (service_req |-> interrupt_req == rs[22])
    else $error("interrupt does not follow exception");
  a_irq_alone: assert property (interrupt_req |-> service_req)
    else $error("interrupt without result");
  a_test_answer: assert property (op_start && op_code == pe_tape_pkg::OP_TEST |-> ##2 service_req)
    else $error("test result late");
  a_test_dens: assert property (service_req && is_test && rs[7] |->
    rs[11:9] == ((rdy && unit_invalid_op) ? pe_tape_pkg::DENS_800 : pe_tape_pkg::DENS_1600))
    else $error("density field wrong");
  a_pause_wait: assert property (service_req && last_ff == pe_tape_pkg::OP_PAUSE |->
    !rs[7] && cnt_ff >= PAUSE_CYCLES)
    else $error("pause result wrong");
  a_unit_map: assert property (op_start |=> drive_number ==
    (($past(unit_select_field) == 4'h0) ? 5'h10 : {1'b0, $past(unit_select_field)}))
    else $error("drive number wrong");
  a_wlock_stop: assert property (op_start && op_code inside {pe_tape_pkg::OP_WRITE, pe_tape_pkg::OP_ERASE}
    && !unit_write_ring && rdy |-> (!motion_enable)[*3] ##0 (service_req && rs[15] && rs[22]))
    else $error("write lockout not refused");
  a_nrdy_start: assert property (op_start && !rdy && op_code inside {pe_tape_pkg::OP_READ,
    pe_tape_pkg::OP_WRITE} |-> ##2 (service_req && rs[21] && rs[22]))
    else $error("not ready not reported");
  a_diag_lvls: assert property (diag_hold == diag_channel_field[3] && diag_read == diag_channel_field[2])
    else $error("diag levels wrong");
  a_even_par: assert property (1'b1 |=> force_even_parity == $past(diag_channel_field[0]))
    else $error("even parity wrong");
  a_undef_zero: assert property (service_req && !is_test && last_ff != pe_tape_pkg::OP_PAUSE |->
    rs[11:8] == 4'h0)
    else $error("undefined bits set");
  cover property (service_req && interrupt_req);
  cover property (service_req && last_ff == pe_tape_pkg::OP_PAUSE);
  cover property (service_req && is_test && rs[7]);
endmodule : pe_tape_control_properties

bind pe_tape_control pe_tape_control_properties #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_props (
  .clk, .reset, .op_start, .op_code, .unit_select_field, .diag_channel_field, .unit_ready,
  .unit_invalid_op, .unit_write_ring, .drive_number, .motion_enable, .diag_hold, .diag_read,
  .force_even_parity, .service_req, .result_status_field, .interrupt_req);

/* verif/pe_tape_deu_model.sv */
`timescale 1ns/1ps
module pe_tape_deu_model (
  input wire logic clk, // clock
  input wire logic motion_enable, // drive may move
  input wire logic [7:0] cfg_lvl, // d800 cmd rew bot eot ring pe ready
  input wire logic [1:0] cfg_stall, // drive reports, never finish
  output logic unit_ready, // ready
  output logic unit_pe, // pe unit
  output logic unit_invalid_op, // 800 bpi switch
  output logic unit_rewinding, // rewinding
  output logic unit_cmd_rewind, // commanded rewind
  output logic unit_write_ring, // ring
  output logic unit_at_eot, // eot
  output logic unit_at_bot, // bot
  output logic motion_done, // pulse
  output logic deu_timeout // pulse
);
  int run_cnt = 0;
  assign {unit_cmd_rewind, unit_rewinding, unit_at_bot, unit_at_eot} = cfg_lvl[6:3];
  assign {unit_write_ring, unit_pe, unit_ready} = cfg_lvl[2:0];
  assign unit_invalid_op = cfg_lvl[7] & cfg_lvl[0];
  initial motion_done = 0;
  initial deu_timeout = 0;
  always @(posedge clk)
  begin
    run_cnt <= motion_enable ? run_cnt + 1 : 0;
    motion_done <= motion_enable && !cfg_stall[0] && run_cnt == 59;
    deu_timeout <= motion_enable && cfg_stall[1] && run_cnt == 99;
  end
endmodule : pe_tape_deu_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct {
    pe_tape_pkg::op_t op;
    logic bwd;
    logic [1:0] ss;
    logic [7:0] lvl;
    int kind;
    logic [23:0] exp;
    logic [23:0] msk;
  } row_t;
  localparam int PAUSE_C = 20;
  localparam logic [23:0] NM = 24'h61_FFFF;
  logic clk = 0;
  logic reset = 1;
  logic op_start = 0;
  pe_tape_pkg::op_t op_code = pe_tape_pkg::OP_NONE;
  logic op_backward = 0;
  logic [1:0] op_store_mode = 2'h0;
  logic [3:0] unit_select_field = 4'h0;
  logic [3:0] diag_channel_field = 4'h0;
  logic [1:0] subsystem_num = 2'h0;
  logic [7:0] cfg_lvl = 8'h07;
  logic [1:0] cfg_stall = 2'h0;
  logic [4:0] pls = 5'h00;
  logic amble_start = 0;
  logic amble_char_valid = 0;
  logic amble_done = 0;
  logic init_err = 0;
  logic [7:0] amble_char = 8'h00;
  logic unit_ready, unit_pe, unit_invalid_op, unit_rewinding, unit_cmd_rewind, unit_write_ring;
  logic unit_at_eot, unit_at_bot, motion_done, deu_timeout, motion_enable, diag_hold, diag_read;
  logic force_even_parity, service_req, interrupt_req, data_xfer_enable;
  logic [4:0] drive_number;
  logic [23:0] result_status_field;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 22907;
  logic [3:0] dg[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  // expectations in printed bit order: value bit n is descriptor bit n
  row_t rows[$] = '{
    '{pe_tape_pkg::OP_TEST, 0, 2'h0, 8'h87, 0, 24'h01_5000, 24'h01_7000},
    '{pe_tape_pkg::OP_TEST, 0, 2'h2, 8'h07, 0, 24'h01_7000, 24'h01_7000},
    '{pe_tape_pkg::OP_TEST, 0, 2'h2, 8'h06, 0, 24'h00_0000, 24'h01_0000},
    '{pe_tape_pkg::OP_TEST, 0, 2'h1, 8'h06, 0, 24'h01_0000, 24'h01_0000},
    '{pe_tape_pkg::OP_TEST, 0, 2'h1, 8'h07, 0, 24'h00_0000, 24'h01_0000},
    '{pe_tape_pkg::OP_TEST, 0, 2'h0, 8'h03, 0, 24'h01_0100, 24'h01_0100},
    '{pe_tape_pkg::OP_PAUSE, 0, 2'h0, 8'h07, 0, 24'h00_0000, 24'h01_0000},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h06, 0, 24'h01_0007, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h05, 0, 24'h01_0007, NM},
    '{pe_tape_pkg::OP_WRITE, 0, 2'h0, 8'h03, 0, 24'h01_0103, NM},
    '{pe_tape_pkg::OP_ERASE, 0, 2'h0, 8'h03, 0, 24'h01_0103, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 1, 24'h41_0003, NM},
    '{pe_tape_pkg::OP_WRITE, 0, 2'h0, 8'h07, 1, 24'h21_0003, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 2, 24'h01_0001, NM},
    '{pe_tape_pkg::OP_SPACE, 0, 2'h0, 8'h07, 2, 24'h01_0001, NM},
    '{pe_tape_pkg::OP_WRITE, 0, 2'h0, 8'h07, 2, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 3, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_ERASE, 0, 2'h0, 8'h07, 4, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 5, 24'h01_0203, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h0F, 0, 24'h01_0043, NM},
    '{pe_tape_pkg::OP_READ, 1, 2'h0, 8'h17, 0, 24'h01_0083, NM},
    '{pe_tape_pkg::OP_REWIND_UNLOAD, 0, 2'h0, 8'h17, 0, 24'h00_0000, 24'h00_0080},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 0, 24'h01_0001, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h27, 0, 24'h01_0407, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h67, 0, 24'h01_0403, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 6, 24'h21_0007, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 135, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 136, 24'h01_0001, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 144, 24'h01_0001, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 145, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 240, 24'h01_000B, NM},
    '{pe_tape_pkg::OP_READ, 0, 2'h0, 8'h07, 9, 24'h01_0803, NM},
    '{pe_tape_pkg::OP_SPACE, 0, 2'h0, 8'h07, 10, 24'h01_0803, NM}
  };

  pe_tape_control #(.PAUSE_CYCLES(PAUSE_C), .TIMEOUT_CYCLES(150)) u_pe_tape_control (
    .clk, .reset, .op_start, .op_code, .op_backward, .op_space_eof(1'b0), .op_store_mode,
    .unit_select_field, .diag_channel_field, .subsystem_num, .unit_present(1'b1), .unit_ready,
    .unit_busy(1'b0), .unit_pe, .unit_invalid_op, .unit_rewinding, .unit_cmd_rewind,
    .unit_write_ring, .unit_at_eot, .unit_at_bot, .init_parity_err(init_err), .data_parity_err(pls[0]),
    .result_parity_err(1'b0), .deu_timeout, .hard_data_err(pls[2]), .soft_data_err(pls[1]),
    .erase_data_seen(pls[3]), .tape_mark_seen(pls[4]), .amble_start, .amble_char_valid,
    .amble_char, .amble_done, .motion_done, .drive_number, .motion_enable,
    .data_xfer_enable, .stop_motion(), .diag_hold, .diag_read, .force_even_parity,
    .service_req, .result_status_field, .interrupt_req);

  pe_tape_deu_model u_pe_tape_deu_model (.clk, .motion_enable, .cfg_lvl, .cfg_stall, .unit_ready,
    .unit_pe, .unit_invalid_op, .unit_rewinding, .unit_cmd_rewind, .unit_write_ring, .unit_at_eot,
    .unit_at_bot, .motion_done, .deu_timeout);

  always #5 clk = ~clk;

  task automatic stop_test;
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (!ok)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  function automatic logic [23:0] rv(input logic [23:0] x);
    logic [23:0] y;
    y = {<<{x}};
    return y;
  endfunction : rv

  task automatic run(input row_t r);
    int n;
    logic [23:0] got;
    logic [3:0] u;
    n = 0;
    u = 4'($random(seed));
    step;
    cfg_lvl = r.lvl;
    cfg_stall = (r.kind == 9) ? 2'h1 : (r.kind == 10) ? 2'h3 : 2'h0;
    op_code = r.op;
    op_backward = r.bwd;
    op_store_mode = r.ss;
    unit_select_field = u;
    subsystem_num = 2'($random(seed));
    step;
    op_start = 1;
    init_err = (r.kind == 6);
    step;
    op_start = 0;
    init_err = 0;
    if (r.kind inside {[1:5]})
    begin
      pls = 5'(1 << (r.kind - 1));
      step;
      pls = 5'h00;
      chk(data_xfer_enable === (r.kind != 5), "data transfer");
    end
    if (r.kind >= 100)
    begin
      // zero count comes from the row, hundreds digit says marker or not
      amble_start = 1;
      step;
      amble_start = 0;
      amble_char_valid = 1;
      for (int i = 0; i < r.kind % 100; i++)
        step;
      amble_char = (r.kind < 200) ? 8'hFF : 8'h7F;
      step;
      amble_char_valid = 0;
      amble_char = 8'h00;
      amble_done = 1;
      step;
      amble_done = 0;
    end
    while (service_req !== 1'b1 && n < 400)
    begin
      step;
      n++;
    end
    got = result_status_field;
    chk(n < 400, "no result");
    chk((got & rv(r.msk)) === (rv(r.exp) & rv(r.msk)), "result bits");
    chk(interrupt_req === got[22], "interrupt");
    chk(drive_number === ((u == 4'h0) ? 5'h10 : {1'b0, u}), "drive number");
    chk(r.op != pe_tape_pkg::OP_PAUSE || n >= PAUSE_C - 2, "pause short");
  endtask : run

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      stop_test;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    reset = 0;
    foreach (rows[i])
      run(rows[i]);
    foreach (dg[i])
    begin
      diag_channel_field = dg[i];
      step;
      step;
      chk({diag_hold, diag_read, force_even_parity} === {dg[i][3], dg[i][2], dg[i][0]}, "diag");
    end
    // forced ready lets a store-if-ready test report a not ready drive
    diag_channel_field = 4'h2;
    run(row_t'{pe_tape_pkg::OP_TEST, 0, 2'h2, 8'h06, 0, 24'h01_7000, 24'h01_7000});
    diag_channel_field = 4'h0;
    stop_test;
  end
endmodule : tb
